// file: bench/ebi_core_sva.sv
/* Pin-level assertions for ebi_core.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/10ps
`default_nettype none
module ebi_core_sva
    import ebi_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic done,
    input wire logic no_area,
    input wire logic bus_8bit,
    input wire logic bus_clk,
    input wire logic addr_oe_n,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [ADDR_W-1:0] addr_out,
    input wire logic [NUM_AREAS-1:0] area_select_n,
    input wire logic read_strobe_n,
    input wire logic store_strobe_upper_lane,
    input wire logic store_strobe_lower_lane,
    input wire logic strobe_oe_n,
    input wire logic store_strobe_lower_lane_oe_n,
    input wire logic ready,
    input wire logic bus_release_ack
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence low_high_s;
        !bus_clk ##1 bus_clk;
    endsequence
    half_rate_a: assert property
        ($rose(bus_clk) |=> low_high_s) else $error("bus clock not half rate");
    addr_hold_a: assert property
        (!(&area_select_n) |-> addr_out == req_addr) else $error("address wrong");
    done_after_a: assert property
        (done && !no_area |-> $past(!(&area_select_n))) else $error("done without cycle");
    one_select_a: assert property
        ($onehot0(~area_select_n)) else $error("two selects low");
    ready_hold_a: assert property
        (!read_strobe_n && !ready |=> !read_strobe_n) else $error("ready ignored");
    narrow_lane_a: assert property
        (bus_8bit && $past(bus_8bit) |-> store_strobe_lower_lane_oe_n) else $error("lower driven");
    reset_float_a: assert property
        (disable iff (1'b0) srst ##1 srst |-> store_strobe_lower_lane_oe_n) else $error("not float");
    release_float_a: assert property
        (!bus_release_ack |-> addr_oe_n && strobe_oe_n) else $error("driven in release");
    read_only_a: assert property
        (!read_strobe_n |-> store_strobe_upper_lane && store_strobe_lower_lane) else $error("rd wr");
endmodule : ebi_core_sva
bind ebi_core ebi_core_sva i_sva (.*);
`default_nettype wire

// file: bench/ebi_core_tb.sv
/* Self-checking bench for ebi_core.
   Assumes ebi_pkg, the checker and the memory model compiled first. */
`timescale 1ns/10ps
`default_nettype none
module ebi_core_tb
    import ebi_pkg::*;
;
    logic clk, srst, req, req_write, done, no_area, bus_8bit, bus_clk, addr_oe_n, ready, clr;
    logic read_strobe_n, store_strobe_upper_lane, store_strobe_lower_lane, strobe_oe_n, slow;
    logic store_strobe_lower_lane_oe_n, data_bus_high_byte_oe_n, bus_release_request;
    logic bus_release_ack, no_area_seen;
    logic [ADDR_W-1:0] req_addr, addr_out;
    logic [1:0] req_byte_en;
    logic [DATA_W-1:0] req_wdata, rdata;
    logic [NUM_AREAS*AREA_BASE_W-1:0] area_base, area_mask;
    logic [NUM_AREAS-1:0] area_enable, area_select_n;
    logic [NUM_AREAS*WAIT_W-1:0] area_waits;
    logic [2:0] le_area;
    logic [7:0] gpio_out, gpio_dir, gpio_in, data_bus_high_byte_in, data_bus_high_byte_out;
    logic [7:0] data_bus_low_byte_pins_in, data_bus_low_byte_pins_out, data_bus_low_byte_pins_oe_n;
    int err_total, checks, cyc;
    ebi_core i_ebi_core (.*);
    ebi_mem i_ebi_mem (.*);
    task automatic close_out;
        if (err_total == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [24:0] a, input logic [15:0] d,
        input logic [1:0] be, output int lat);
        @(posedge clk);
        {clr, req, req_write, req_addr, req_wdata, req_byte_en} <= {2'h3, w, a, d, be};
        @(posedge clk);
        clr <= 1'b0;
        lat = 1;
        do begin
            @(negedge clk);
            lat++;
        end while (done !== 1'b1 && lat < 300);
        no_area_seen = no_area;
        chk("done", 1'b1, done);
        @(posedge clk);
        req <= 1'b0;
    endtask : acc
    task automatic t_waits;
        int lat;
        for (int w = 0; w < 8; w++) begin
            area_waits <= (NUM_AREAS*WAIT_W)'(w);
            acc(1'b1, 25'h0000102, 16'hB0E0 + 16'(w), 2'h3, lat);
            chk("lat", 1, (lat - 2 * w) inside {6, 7});
            chk("wr", {2'h3, 16'hB0E0 + 16'(w)}, {i_ebi_mem.got, i_ebi_mem.wr_hi, i_ebi_mem.wr_lo});
        end
    endtask : t_waits
    task automatic t_read;
        int lat;
        area_waits <= '0;
        acc(1'b0, 25'h0000034, 16'h0, 2'h3, lat);
        chk("rd", 16'hF734, rdata);
        le_area <= 3'h1;
        acc(1'b0, 25'h0010034, 16'h0, 2'h3, lat);
        chk("le_rd", 16'h34F7, rdata);
        acc(1'b1, 25'h0010034, 16'h1234, 2'h1, lat);
        chk("le_wr", 10'h234, {i_ebi_mem.got, i_ebi_mem.wr_hi});
        le_area <= 3'h0;
        slow <= 1'b1;
        acc(1'b0, 25'h0000034, 16'h0, 2'h3, lat);
        chk("slow", {1'b1, 16'hF734}, {lat > 7, rdata});
        slow <= 1'b0;
    endtask : t_read
    task automatic t_misc;
        int lat;
        logic [7:0] pins_seen;
        acc(1'b0, 25'h1000000, 16'h0, 2'h3, lat);
        chk("no_area", 1'b1, no_area_seen);
        {bus_8bit, gpio_dir, gpio_out} <= {1'b1, 16'hFF5A};
        acc(1'b1, 25'h0000010, 16'hC3A5, 2'h2, lat);
        @(negedge clk);
        pins_seen = ~(i_ebi_mem.pat - 8'h1);
        chk("n8", 10'h2A5, {i_ebi_mem.got, i_ebi_mem.wr_hi});
        chk("gpio", 16'h005A, {data_bus_low_byte_pins_oe_n, data_bus_low_byte_pins_out});
        chk("gpio_in", pins_seen, gpio_in);
        @(posedge clk);
        bus_8bit <= 1'b0;
        bus_release_request <= 1'b1;
        repeat (6) @(negedge clk);
        chk("rel", 2'h1, {bus_release_ack, addr_oe_n});
        @(posedge clk);
        bus_release_request <= 1'b0;
        repeat (6) @(negedge clk);
        chk("rel_end", 1'b1, bus_release_ack);
    endtask : t_misc
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            close_out();
        end
    end
    initial begin
        {srst, req, req_write, req_addr, req_byte_en, req_wdata, bus_8bit, clr, slow} = '0;
        srst = 1'b1;
        {area_base, area_mask, area_enable} = {36'h0, 9'h001, 9'h000, 54'h0, 6'h03};
        {area_waits, le_area, gpio_out, gpio_dir, bus_release_request} = '0;
        repeat (4) @(negedge clk);
        chk("rst", 8'hFF, {store_strobe_lower_lane_oe_n, bus_release_ack, area_select_n});
        @(posedge clk);
        srst <= 1'b0;
        t_waits();
        t_read();
        t_misc();
        close_out();
    end
endmodule : ebi_core_tb
`default_nettype wire

// file: bench/ebi_mem.sv
/* External memory model on the ebi_core pins.
   Assumes active-low selects and strobes, pull-up on the lower strobe. */
`timescale 1ns/10ps
`default_nettype none
module ebi_mem
    import ebi_pkg::*;
(
    input wire logic clk,
    input wire logic slow,
    input wire logic clr,
    input wire logic [NUM_AREAS-1:0] area_select_n,
    input wire logic read_strobe_n,
    input wire logic store_strobe_upper_lane,
    input wire logic store_strobe_lower_lane,
    input wire logic store_strobe_lower_lane_oe_n,
    input wire logic [ADDR_W-1:0] addr_out,
    input wire logic [7:0] data_bus_high_byte_out,
    input wire logic data_bus_high_byte_oe_n,
    input wire logic [7:0] data_bus_low_byte_pins_out,
    output logic [7:0] data_bus_high_byte_in,
    output logic [7:0] data_bus_low_byte_pins_in,
    output logic ready
);
    logic [7:0] pat = 8'h00;
    logic [2:0] k = 3'h0;
    logic [7:0] wr_hi, wr_lo;
    logic [1:0] got;
    logic rd, lo_st;
    assign rd = !(&area_select_n) && !read_strobe_n;
    assign lo_st = store_strobe_lower_lane_oe_n | store_strobe_lower_lane;
    // Lines change every cycle outside a selected read, except the high byte, which echoes the core while it drives it
    assign data_bus_high_byte_in = !data_bus_high_byte_oe_n ? data_bus_high_byte_out :
        rd ? addr_out[7:0] ^ 8'hC3 : pat;
    assign data_bus_low_byte_pins_in = rd ? addr_out[7:0] : ~pat;
    assign ready = !slow || k[2];
    always @(posedge clk) begin
        pat <= pat + 8'h1;
        if (read_strobe_n && store_strobe_upper_lane && lo_st) begin
            k <= 3'h0;
        end else if (!k[2]) begin
            k <= k + 3'h1;
        end
        if (clr) begin
            got <= 2'h0;
        end
        if (!store_strobe_upper_lane) begin
            got[1] <= 1'b1;
            wr_hi <= data_bus_high_byte_out;
        end
        if (!lo_st) begin
            got[0] <= 1'b1;
            wr_lo <= data_bus_low_byte_pins_out;
        end
    end
endmodule : ebi_mem
`default_nettype wire

// file: logic/ebi_area_decode.sv
/*
 * Chip-select area decoder: matches the upper address bits against six
 * programmable base/mask pairs in 64 KB granules.
 * Assumes configuration is static during an access.
 */
`timescale 1ns/10ps
`default_nettype none
module ebi_area_decode
    import ebi_pkg::*;
(
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [NUM_AREAS*AREA_BASE_W-1:0] area_base,
    input wire logic [NUM_AREAS*AREA_BASE_W-1:0] area_mask,
    input wire logic [NUM_AREAS-1:0] area_enable,
    output logic [NUM_AREAS-1:0] hit,
    output logic [2:0] hit_index,
    output logic any_hit
);
    logic [AREA_BASE_W-1:0] granule;

    assign granule = addr[ADDR_W-1:ADDR_W-AREA_BASE_W];

    // ------------------------------------------------------------
    // Per-area compare, mask bit set means don't care
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_AREAS; g++) begin : g_area
            assign hit[g] = area_enable[g] &&
                (((granule ^ area_base[g*AREA_BASE_W +: AREA_BASE_W])
                  & ~area_mask[g*AREA_BASE_W +: AREA_BASE_W]) == '0);
        end
    endgenerate

    // Lowest area wins on overlap
    always_comb begin
        hit_index = 3'h0;
        for (int i = NUM_AREAS - 1; i >= 0; i--) begin
            if (hit[i]) begin
                hit_index = 3'(i);
            end
        end
    end

    assign any_hit = |hit;
endmodule : ebi_area_decode
`default_nettype wire

// file: logic/ebi_core.sv
/*
 * External bus interface controller: one access at a time from the core
 * side, strobes and selects toward external memory, bus release handover.
 * Assumes all inputs synchronous to clk; request held until done pulses.
 */
`timescale 1ns/10ps
`default_nettype none
module ebi_core
    import ebi_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    // Core side request
    input wire logic req,
    input wire logic req_write,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [1:0] req_byte_en,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic done,
    output logic [DATA_W-1:0] rdata,
    output logic no_area,
    // Configuration
    input wire logic bus_8bit,
    input wire logic [NUM_AREAS*AREA_BASE_W-1:0] area_base,
    input wire logic [NUM_AREAS*AREA_BASE_W-1:0] area_mask,
    input wire logic [NUM_AREAS-1:0] area_enable,
    input wire logic [NUM_AREAS*WAIT_W-1:0] area_waits,
    input wire logic [2:0] le_area,
    input wire logic [7:0] gpio_out,
    input wire logic [7:0] gpio_dir,
    output logic [7:0] gpio_in,
    // External pins
    output logic bus_clk,
    output logic [ADDR_W-1:0] addr_out,
    output logic addr_oe_n,
    output logic [NUM_AREAS-1:0] area_select_n,
    output logic read_strobe_n,
    output logic store_strobe_upper_lane,
    output logic store_strobe_lower_lane,
    output logic strobe_oe_n,
    output logic store_strobe_lower_lane_oe_n,
    input wire logic [7:0] data_bus_high_byte_in,
    output logic [7:0] data_bus_high_byte_out,
    output logic data_bus_high_byte_oe_n,
    input wire logic [7:0] data_bus_low_byte_pins_in,
    output logic [7:0] data_bus_low_byte_pins_out,
    output logic [7:0] data_bus_low_byte_pins_oe_n,
    input wire logic ready,
    input wire logic bus_release_request,
    output logic bus_release_ack
);
    ebi_state_t state;
    ebi_state_t next_state;
    logic phase;
    logic [2:0] wait_left;
    logic [NUM_AREAS-1:0] hit;
    logic [2:0] hit_index;
    logic any_hit;
    logic [2:0] cur_area;
    logic swap;
    logic [DATA_W-1:0] lane_wdata;
    logic [1:0] lane_be;
    logic data_last;

    ebi_area_decode u_decode (
        .addr(req_addr),
        .area_base(area_base),
        .area_mask(area_mask),
        .area_enable(area_enable),
        .hit(hit),
        .hit_index(hit_index),
        .any_hit(any_hit)
    );

    // ------------------------------------------------------------
    // Bus clock and phase
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            phase <= 1'b0;
            bus_clk <= 1'b0;
        end else begin
            phase <= ~phase;
            bus_clk <= phase;
        end
    end

    // Little-endian area swaps the two byte lanes
    assign swap = !bus_8bit && (le_area >= LE_AREA_MIN) && (le_area <= LE_AREA_MAX)
        && (hit_index == le_area);
    assign lane_wdata = swap ? {req_wdata[7:0], req_wdata[15:8]} : req_wdata;
    assign lane_be = swap ? {req_byte_en[0], req_byte_en[1]} : req_byte_en;
    assign data_last = (wait_left == 3'h0) && ready && phase;

    // ------------------------------------------------------------
    // Sequencer, transitions on bus clock boundaries except END to IDLE, which follows one core cycle later
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            EBI_IDLE: begin
                if (phase && bus_release_request) begin
                    next_state = EBI_REL;
                end else if (phase && req && any_hit) begin
                    next_state = EBI_ADDR;
                end
            end
            EBI_ADDR: begin
                if (phase) begin
                    next_state = EBI_DATA;
                end
            end
            EBI_DATA: begin
                if (data_last) begin
                    next_state = EBI_END;
                end
            end
            EBI_END: next_state = EBI_IDLE;
            EBI_REL: begin
                if (phase && !bus_release_request) begin
                    next_state = EBI_IDLE;
                end
            end
            default: next_state = EBI_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= EBI_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Wait counter
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            wait_left <= 3'h0;
            cur_area <= 3'h0;
        end else if (state == EBI_IDLE && next_state == EBI_ADDR) begin
            cur_area <= hit_index;
            wait_left <= area_waits[hit_index*WAIT_W +: WAIT_W];
        end else if (state == EBI_DATA && phase && wait_left != 3'h0) begin
            wait_left <= wait_left - 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Address, selects and strobes
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            addr_out <= '0;
            area_select_n <= '1;
            read_strobe_n <= 1'b1;
            store_strobe_upper_lane <= 1'b1;
            store_strobe_lower_lane <= 1'b1;
            data_bus_high_byte_out <= 8'h00;
            data_bus_low_byte_pins_out <= 8'h00;
        end else begin
            if (state == EBI_IDLE && next_state == EBI_ADDR) begin
                addr_out <= req_addr;
                area_select_n <= ~(hit & (~hit + NUM_AREAS'(1)));
                data_bus_high_byte_out <= bus_8bit ? req_wdata[7:0] : lane_wdata[15:8];
                if (!bus_8bit) begin
                    data_bus_low_byte_pins_out <= lane_wdata[7:0];
                end
            end else if (next_state == EBI_END || next_state == EBI_REL
                         || next_state == EBI_IDLE) begin
                area_select_n <= '1;
            end
            if (bus_8bit && state != EBI_ADDR && state != EBI_DATA) begin
                data_bus_low_byte_pins_out <= gpio_out;
            end
            if (next_state == EBI_DATA && !req_write) begin
                read_strobe_n <= 1'b0;
            end else begin
                read_strobe_n <= 1'b1;
            end
            if (next_state == EBI_DATA && req_write) begin
                store_strobe_upper_lane <= bus_8bit ? 1'b0 : ~lane_be[1];
                store_strobe_lower_lane <= bus_8bit ? 1'b1 : ~lane_be[0];
            end else begin
                store_strobe_upper_lane <= 1'b1;
                store_strobe_lower_lane <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Output enables
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            addr_oe_n <= 1'b0;
            strobe_oe_n <= 1'b0;
            store_strobe_lower_lane_oe_n <= 1'b1;
            data_bus_high_byte_oe_n <= 1'b1;
            data_bus_low_byte_pins_oe_n <= 8'hFF;
            bus_release_ack <= 1'b1;
        end else begin
            addr_oe_n <= (next_state == EBI_REL);
            strobe_oe_n <= (next_state == EBI_REL);
            store_strobe_lower_lane_oe_n <= (next_state == EBI_REL) || bus_8bit;
            bus_release_ack <= ~(next_state == EBI_REL);
            data_bus_high_byte_oe_n <= ~((next_state == EBI_ADDR || next_state == EBI_DATA)
                && req_write);
            if (bus_8bit) begin
                data_bus_low_byte_pins_oe_n <= ~gpio_dir;
            end else begin
                data_bus_low_byte_pins_oe_n <= {8{~((next_state == EBI_ADDR
                    || next_state == EBI_DATA) && req_write)}};
            end
        end
    end

    // ------------------------------------------------------------
    // Read capture and completion
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= '0;
            done <= 1'b0;
            no_area <= 1'b0;
            gpio_in <= 8'h00;
        end else begin
            gpio_in <= data_bus_low_byte_pins_in;
            done <= (state == EBI_DATA && data_last)
                || (state == EBI_IDLE && phase && req && !any_hit && !bus_release_request);
            no_area <= (state == EBI_IDLE && phase && req && !any_hit
                && !bus_release_request);
            if (state == EBI_DATA && data_last && !req_write) begin
                if (bus_8bit) begin
                    rdata <= {8'h00, data_bus_high_byte_in};
                end else if (cur_area == le_area && le_area != LE_AREA_NONE) begin
                    rdata <= {data_bus_low_byte_pins_in, data_bus_high_byte_in};
                end else begin
                    rdata <= {data_bus_high_byte_in, data_bus_low_byte_pins_in};
                end
            end
        end
    end
endmodule : ebi_core
`default_nettype wire

// file: shared/ebi_pkg.sv
/*
 * Constants and types shared by the external bus interface.
 * Assumes a single 100 MHz core clock and a synchronous active-high reset.
 */
package ebi_pkg;
    // ------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 25;
    localparam int DATA_W = 16;
    localparam int NUM_AREAS = 6;
    localparam int AREA_BASE_W = 9;
    localparam int WAIT_W = 3;
    localparam logic [2:0] WAIT_MAX = 3'h7;
    localparam logic [2:0] LE_AREA_MIN = 3'h1;
    localparam logic [2:0] LE_AREA_MAX = 3'h5;
    localparam logic [2:0] LE_AREA_NONE = 3'h0;
    // ------------------------------------------------------------
    // Clocking
    // ------------------------------------------------------------
    localparam int CORE_MHZ = 100;
    localparam int BUS_DIV = 2;
    localparam int BASE_BUS_CYCLES = 2;
    localparam int BASE_CORE_CYCLES = BASE_BUS_CYCLES * BUS_DIV;
    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        EBI_IDLE = 5'h01,
        EBI_ADDR = 5'h02,
        EBI_DATA = 5'h04,
        EBI_END = 5'h08,
        EBI_REL = 5'h10
    } ebi_state_t;
endpackage : ebi_pkg
